// ---- adcc_pkg.sv ----
package adcc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [3:0] ADCC_OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADCC_OFS_CTRL_TWO = 4'h4;
  localparam logic [3:0] ADCC_OFS_RES_LO = 4'h8;
  localparam logic [3:0] ADCC_OFS_RES_HI = 4'hc;
  // control one fields
  localparam int ADCC_C1_START = 7;
  localparam int ADCC_C1_BUSY = 6;
  localparam int ADCC_C1_POFF = 5;
  localparam int ADCC_C1_CH_HI = 4;
  localparam int ADCC_CH_TOP = 4;
  // control two fields
  localparam int ADCC_C2_BGEN = 6;
  localparam int ADCC_C2_FMT = 5;
  localparam int ADCC_C2_REF = 4;
  localparam int ADCC_C2_DIV_HI = 2;
  // reset values
  localparam logic ADCC_RST_BUSY = 1'b1;
  localparam logic ADCC_RST_POFF = 1'b1;
  localparam logic [4:0] ADCC_RST_CH = 5'h00;
  localparam logic ADCC_RST_BGEN = 1'b1;
  localparam logic ADCC_RST_FMT = 1'b1;
  localparam logic ADCC_RST_REF = 1'b0;
  localparam logic [2:0] ADCC_RST_DIV = 3'h0;
  // pin function code for the external reference pin
  localparam logic [3:0] ADCC_PH_VREF_CODE = 4'h3;
  // conversion length in converter clocks
  localparam int ADCC_CONV_CLKS = 16;
  localparam int ADCC_NUM_CH = 12;
  localparam int ADCC_RES_BITS = 12;
  localparam logic [5:0] ADCC_DIV_MAX = 6'h3f;
  localparam logic [2:0] ADCC_DIV_UNDEF = 3'h7;

  typedef struct packed {
    logic start;
    logic power_off;
    logic [4:0] channel_select;
    logic bandgap_enable;
    logic result_format_select;
    logic reference_select;
    logic [2:0] conv_clock_divider_select;
  } adcc_ctrl_t;

  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_RESET = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

// ---- adcc_top.sv ----
// Functional notes
// - bandgap enable feeds bandgap to converter
// - bandgap off unless used or supervisor on
// - format bit places result in two bytes
// - reference select picks external pin or supply
// - divider field divides clock, 111 undefined
// - low-high-low start pulse starts one conversion
// - start high holds reset, busy high
// - busy clears when conversion finishes
// - end of conversion sets interrupt request
// - power-off bit shuts converter down
// - reference pin takes shared pin on code 0011
// - analog pin drops digital function, pull-high
// - analog selection overrides port direction
// - conversion lasts 16 converter clocks
// - result 12-bit unsigned, full scale fff
// - control two bit 3 reads zero
// - channel codes 0-11 inputs, top bit bandgap
// - unused result bits read zero
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NUM_PINS = ADCC_NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic converter_interrupt_enable,
  input wire logic global_interrupt_enable,
  input wire logic low_voltage_supervisor,
  input wire logic [3:0] porth_pin_function_field,
  input wire logic [NUM_PINS-1:0] analog_pin_select,
  input wire logic [NUM_PINS-1:0] pull_high_request,
  input wire logic [NUM_PINS-1:0] port_output_request,
  input wire logic comparator_bit,
  output logic conv_irq_req,
  output logic conv_irq,
  output logic conv_clk_en,
  output logic conv_reset,
  output logic conv_sample,
  output logic conv_powered,
  output logic [4:0] conv_input_select,
  output logic bandgap_to_converter,
  output logic bandgap_power,
  output logic ref_from_pin,
  output logic vref_pin_claim,
  output logic [NUM_PINS-1:0] pull_high_en,
  output logic [NUM_PINS-1:0] port_drive_en,
  output logic [NUM_PINS-1:0] digital_func_en,
  output logic [11:0] result_value
);

  adcc_ctrl_t ctrl_ff;
  adcc_state_t state_ff;
  logic busy_ff;
  logic [11:0] sar_ff;
  logic [11:0] result_ff;
  logic [5:0] div_cnt_ff;
  logic tick_ff;
  logic [4:0] bit_cnt_ff;
  logic irq_req_ff;
  logic irq_ff;
  logic [31:0] dat_ff;
  logic ack_ff;
  logic clk_en_ff;
  logic reset_ff;
  logic sample_ff;
  logic powered_ff;
  logic [4:0] in_sel_ff;
  logic bg_conv_ff;
  logic bg_pwr_ff;
  logic ref_pin_ff;
  logic vref_claim_ff;
  logic [NUM_PINS-1:0] pull_ff;
  logic [NUM_PINS-1:0] drive_ff;
  logic [NUM_PINS-1:0] dig_ff;

  logic bus_req;
  logic wr_c1;
  logic wr_c2;
  logic start_rise;
  logic start_fall;
  logic conv_done;
  logic [5:0] div_mask;
  logic [7:0] res_lo;
  logic [7:0] res_hi;

  // divider terminal mask: 2^code - 1, code 7 takes the code 6 mask
  function automatic logic [5:0] div_mask_of(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      3'h0: m = 6'h00;
      3'h1: m = 6'h01;
      3'h2: m = 6'h03;
      3'h3: m = 6'h07;
      3'h4: m = 6'h0f;
      3'h5: m = 6'h1f;
      3'h6: m = 6'h3f;
      default: m = ADCC_DIV_MAX;
    endcase
    return m;
  endfunction : div_mask_of

  // byte lane write helper
  function automatic logic lane_wr(input logic [3:0] sel);
    return sel[0];
  endfunction : lane_wr

  // request taken while ack is low; writes need lane 0
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_c1 = bus_req && wb_we_i && lane_wr(wb_sel_i) && (wb_adr_i == ADCC_OFS_CTRL_ONE);
  assign wr_c2 = bus_req && wb_we_i && lane_wr(wb_sel_i) && (wb_adr_i == ADCC_OFS_CTRL_TWO);
  // start bit edges written by software
  assign start_rise = wr_c1 && wb_dat_i[ADCC_C1_START] && !ctrl_ff.start;
  assign start_fall = wr_c1 && !wb_dat_i[ADCC_C1_START] && ctrl_ff.start;
  assign div_mask = div_mask_of(ctrl_ff.conv_clock_divider_select);
  // last converter tick; a restart in the same cycle wins
  assign conv_done = (state_ff == ADCC_CONV) && tick_ff && !start_rise
                     && (bit_cnt_ff == 5'(ADCC_CONV_CLKS - 1));

  // result byte layout
  always_comb begin
    if (ctrl_ff.result_format_select) begin
      res_hi = {4'h0, result_ff[11:8]};
      res_lo = result_ff[7:0];
    end else begin
      res_hi = result_ff[11:4];
      res_lo = {result_ff[3:0], 4'h0};
    end
  end

  // bus slave: one wait cycle, ack for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // read data, valid while ack stands
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_ff <= 32'h0;
    end else if (bus_req) begin
      unique case (wb_adr_i)
        ADCC_OFS_CTRL_ONE: dat_ff <= {24'h0, ctrl_ff.start, busy_ff, ctrl_ff.power_off, ctrl_ff.channel_select};
        ADCC_OFS_CTRL_TWO: dat_ff <= {24'h0, 1'b0, ctrl_ff.bandgap_enable, ctrl_ff.result_format_select,
                                      ctrl_ff.reference_select, 1'b0, ctrl_ff.conv_clock_divider_select};
        ADCC_OFS_RES_LO: dat_ff <= {24'h0, res_lo};
        ADCC_OFS_RES_HI: dat_ff <= {24'h0, res_hi};
        default: dat_ff <= 32'h0;
      endcase
    end
  end

  // control registers, both written from the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff.start <= 1'b0;
      ctrl_ff.power_off <= ADCC_RST_POFF;
      ctrl_ff.channel_select <= ADCC_RST_CH;
      ctrl_ff.bandgap_enable <= ADCC_RST_BGEN;
      ctrl_ff.result_format_select <= ADCC_RST_FMT;
      ctrl_ff.reference_select <= ADCC_RST_REF;
      ctrl_ff.conv_clock_divider_select <= ADCC_RST_DIV;
    end else begin
      if (wr_c1) begin
        ctrl_ff.start <= wb_dat_i[ADCC_C1_START];
        ctrl_ff.power_off <= wb_dat_i[ADCC_C1_POFF];
        ctrl_ff.channel_select <= wb_dat_i[ADCC_C1_CH_HI:0];
      end
      if (wr_c2) begin
        ctrl_ff.bandgap_enable <= wb_dat_i[ADCC_C2_BGEN];
        ctrl_ff.result_format_select <= wb_dat_i[ADCC_C2_FMT];
        ctrl_ff.reference_select <= wb_dat_i[ADCC_C2_REF];
        ctrl_ff.conv_clock_divider_select <= wb_dat_i[ADCC_C2_DIV_HI:0];
      end
    end
  end

  // converter clock divider, one-cycle tick per converter clock
  always_ff @(posedge clk) begin
    if (rst || state_ff != ADCC_CONV) begin
      div_cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else if ((div_cnt_ff & div_mask) == div_mask) begin
      div_cnt_ff <= 6'h00;
      // the undefined code stalls the converter clock
      tick_ff <= (ctrl_ff.conv_clock_divider_select != ADCC_DIV_UNDEF);
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
      tick_ff <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ADCC_IDLE;
    end else if (ctrl_ff.power_off) begin
      // power-off abandons a conversion
      state_ff <= ADCC_IDLE;
    end else begin
      unique case (state_ff)
        ADCC_IDLE: if (start_rise) state_ff <= ADCC_RESET;
        ADCC_RESET: if (start_fall) state_ff <= ADCC_CONV;
        ADCC_CONV: begin
          // a start write while converting restarts
          if (start_rise) begin
            state_ff <= ADCC_RESET;
          end else if (conv_done) begin
            state_ff <= ADCC_IDLE;
          end
        end
      endcase
    end
  end

  // converter ticks since sampling began
  always_ff @(posedge clk) begin
    if (rst || state_ff != ADCC_CONV) begin
      bit_cnt_ff <= 5'h00;
    end else if (tick_ff) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // successive approximation register against the comparator
  always_ff @(posedge clk) begin
    if (rst || state_ff != ADCC_CONV) begin
      sar_ff <= 12'h0;
    end else if (tick_ff && bit_cnt_ff < 5'(ADCC_RES_BITS)) begin
      sar_ff <= {sar_ff[10:0], comparator_bit};
    end
  end

  // result kept until the next finished conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      result_ff <= 12'h0;
    end else if (conv_done) begin
      result_ff <= sar_ff;
    end
  end

  // busy flag
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= ADCC_RST_BUSY;
    end else if (start_rise) begin
      busy_ff <= 1'b1;
    end else if (conv_done) begin
      busy_ff <= 1'b0;
    end
  end

  // interrupt request: set on conv_done, cleared by start_rise; a restart in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_req_ff <= conv_done || (irq_req_ff && !start_rise);
      // pulse only with both enables set
      irq_ff <= conv_done && converter_interrupt_enable && global_interrupt_enable;
    end
  end

  // analog side controls
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_en_ff <= 1'b0;
      reset_ff <= 1'b1;
      sample_ff <= 1'b0;
      powered_ff <= 1'b0;
      in_sel_ff <= ADCC_RST_CH;
      bg_conv_ff <= 1'b0;
      bg_pwr_ff <= 1'b0;
      ref_pin_ff <= 1'b0;
      vref_claim_ff <= 1'b0;
    end else begin
      clk_en_ff <= tick_ff;
      reset_ff <= (state_ff != ADCC_CONV);
      sample_ff <= (state_ff == ADCC_RESET) && start_fall
                   && !ctrl_ff.power_off;
      powered_ff <= !ctrl_ff.power_off;
      in_sel_ff <= ctrl_ff.channel_select;
      // bandgap and reference routing
      bg_conv_ff <= ctrl_ff.bandgap_enable && ctrl_ff.channel_select[ADCC_CH_TOP];
      bg_pwr_ff <= (ctrl_ff.bandgap_enable && !ctrl_ff.power_off) || low_voltage_supervisor;
      ref_pin_ff <= ctrl_ff.reference_select;
      vref_claim_ff <= ctrl_ff.reference_select && (porth_pin_function_field == ADCC_PH_VREF_CODE);
    end
  end

  // pin sharing overrides
  always_ff @(posedge clk) begin
    if (rst) begin
      pull_ff <= '0;
      drive_ff <= '0;
      dig_ff <= '1;
    end else begin
      // an analog pin loses pull-high, drive and digital use
      pull_ff <= pull_high_request & ~analog_pin_select;
      drive_ff <= port_output_request & ~analog_pin_select;
      dig_ff <= ~analog_pin_select;
    end
  end

  // outputs straight from their flip-flops
  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign conv_irq_req = irq_req_ff;
  assign conv_irq = irq_ff;
  assign conv_clk_en = clk_en_ff;
  assign conv_reset = reset_ff;
  assign conv_sample = sample_ff;
  assign conv_powered = powered_ff;
  assign conv_input_select = in_sel_ff;
  assign bandgap_to_converter = bg_conv_ff;
  assign bandgap_power = bg_pwr_ff;
  assign ref_from_pin = ref_pin_ff;
  assign vref_pin_claim = vref_claim_ff;
  assign pull_high_en = pull_ff;
  assign port_drive_en = drive_ff;
  assign digital_func_en = dig_ff;
  assign result_value = result_ff;

endmodule : adcc_top

// ---- adcc_top_props.sv ----
module adcc_top_props
  import adcc_pkg::*;
#(
  parameter int NUM_PINS = ADCC_NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic low_voltage_supervisor,
  input wire logic [3:0] porth_pin_function_field,
  input wire logic [NUM_PINS-1:0] analog_pin_select,
  input wire logic conv_irq_req,
  input wire logic conv_irq,
  input wire logic conv_clk_en,
  input wire logic conv_reset,
  input wire logic conv_sample,
  input wire logic conv_powered,
  input wire logic [4:0] conv_input_select,
  input wire logic bandgap_to_converter,
  input wire logic bandgap_power,
  input wire logic ref_from_pin,
  input wire logic vref_pin_claim,
  input wire logic [NUM_PINS-1:0] digital_func_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic live_ff;
  logic [4:0] tick_ff;
  always_ff @(posedge clk) live_ff <= !rst;
  // converter ticks since the converter left reset
  always_ff @(posedge clk) begin
    if (rst || conv_sample) tick_ff <= 5'h00;
    else if (conv_clk_en) tick_ff <= tick_ff + 5'h01;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_start;
    wb_ack_o && wb_we_i && wb_adr_i == ADCC_OFS_CTRL_ONE && wb_dat_i[ADCC_C1_START];
  endsequence
  sequence s_end;
    $rose(conv_irq_req);
  endsequence
  a_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  a_start_reset: assert property (s_start |-> ##[1:2] conv_reset) else $error("no reset");
  a_sample_conv: assert property (conv_sample |-> ##[0:1] !conv_reset) else $error("sample in reset");
  a_conv_len: assert property (s_end |-> ##[0:2] tick_ff == 5'h10) else $error("tick count");
  a_tick_max: assert property (tick_ff <= 5'h10) else $error("too many ticks");
  a_irq_pulse: assert property (conv_irq |-> conv_irq_req ##1 !conv_irq) else $error("irq");
  a_bg_route: assert property (bandgap_to_converter |-> conv_input_select[ADCC_CH_TOP]) else $error("bg");
  a_bg_off: assert property (live_ff && !conv_powered && !$past(low_voltage_supervisor) |-> !bandgap_power)
    else $error("bandgap on");
  a_bg_keep: assert property (live_ff && $past(low_voltage_supervisor) |-> bandgap_power)
    else $error("bandgap off");
  a_vref_pin: assert property (live_ff |-> vref_pin_claim == (ref_from_pin
    && $past(porth_pin_function_field) == ADCC_PH_VREF_CODE)) else $error("vref pin");
  a_analog_pin: assert property (live_ff |-> digital_func_en == ~$past(analog_pin_select))
    else $error("pin function");
endmodule : adcc_top_props

bind adcc_top adcc_top_props #(.NUM_PINS(NUM_PINS)) i_props (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .low_voltage_supervisor, .porth_pin_function_field, .analog_pin_select,
  .conv_irq_req, .conv_irq, .conv_clk_en, .conv_reset, .conv_sample, .conv_powered, .conv_input_select,
  .bandgap_to_converter, .bandgap_power, .ref_from_pin, .vref_pin_claim, .digital_func_en);

// ---- adcc_analog_model.sv ----
module adcc_analog_model (
  input wire logic clk,
  input wire logic conv_reset,
  input wire logic conv_clk_en,
  input wire logic [11:0] level,
  output logic comparator_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  // one decision per converter tick, msb first
  always @(posedge clk) begin
    if (conv_reset) idx <= 0;
    else if (conv_clk_en) idx <= idx + 1;
  end
  assign comparator_bit = (idx < 12) ? level[11 - idx] : ~level[0];
endmodule : adcc_analog_model

// ---- adcc_top_tb.sv ----
module adcc_top_tb;
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, porth_pin_function_field = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, converter_interrupt_enable = 1'b0, global_interrupt_enable = 1'b0;
  logic low_voltage_supervisor = 1'b0, comparator_bit, conv_irq_req, conv_irq, conv_clk_en;
  logic conv_reset, conv_sample, conv_powered, bandgap_to_converter, bandgap_power, ref_from_pin, vref_pin_claim;
  logic [11:0] analog_pin_select = 12'h0, pull_high_request = 12'h0, port_output_request = 12'h0;
  logic [11:0] level = 12'h0, pull_high_en, port_drive_en, digital_func_en, result_value;
  logic [4:0] conv_input_select;
  logic [15:0] rnd_ff = 16'h0012, pin_ff = 16'h0012;
  logic [8:0] expq[$];
  logic [8:0] e9;
  logic [7:0] q;
  logic [11:0] pull_exp_ff = 12'h0, drive_exp_ff = 12'h0;
  logic live_ff = 1'b0;
  int fail_count = 0, comparisons = 0, cycles = 0, irqs = 0, polls = 0;
  adcc_top i_dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .converter_interrupt_enable, .global_interrupt_enable, .low_voltage_supervisor,
    .porth_pin_function_field, .analog_pin_select, .pull_high_request, .port_output_request, .comparator_bit,
    .conv_irq_req, .conv_irq, .conv_clk_en, .conv_reset, .conv_sample, .conv_powered, .conv_input_select,
    .bandgap_to_converter, .bandgap_power, .ref_from_pin, .vref_pin_claim, .pull_high_en, .port_drive_en,
    .digital_func_en, .result_value);
  adcc_analog_model i_far (.clk, .conv_reset, .conv_clk_en, .level, .comparator_bit);
  always #12.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("%0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic c, input logic [7:0] e);
    expq.push_back({c, e});
    wb(1'b0, a, 8'h00);
  endtask : rd
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      e9 = expq.pop_front();
      if (e9[8]) check(wb_dat_o, {24'h0, e9[7:0]});
    end
    if (conv_irq === 1'b1) irqs++;
  end
  always @(posedge clk) begin
    cycles++;
    pin_ff <= lfsr(pin_ff);
    analog_pin_select <= pin_ff[11:0];
    pull_high_request <= pin_ff[15:4];
    port_output_request <= pin_ff[13:2];
    porth_pin_function_field <= pin_ff[5:2];
    low_voltage_supervisor <= pin_ff[14];
    live_ff <= !rst;
    pull_exp_ff <= pull_high_request & ~analog_pin_select;
    drive_exp_ff <= port_output_request & ~analog_pin_select;
    if (live_ff) begin
      check(32'(pull_high_en), 32'(pull_exp_ff));
      check(32'(port_drive_en), 32'(drive_exp_ff));
    end
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(ADCC_OFS_CTRL_ONE, 1'b1, 8'h60);
    rd(ADCC_OFS_CTRL_TWO, 1'b1, 8'h60);
    rd(4'h2, 1'b1, 8'h00);
    rd(ADCC_OFS_RES_HI, 1'b1, 8'h00);
    check(32'(conv_powered), 32'h0);
    wb(1'b1, ADCC_OFS_CTRL_TWO, 8'hff);
    rd(ADCC_OFS_CTRL_TWO, 1'b1, 8'h77);
    wb(1'b1, ADCC_OFS_RES_LO, 8'h5a);
    rd(ADCC_OFS_RES_LO, 1'b1, 8'h00);
    $display("register test done");
    for (int f = 0; f < 2; f++) begin
      rnd_ff = lfsr(rnd_ff);
      level <= rnd_ff[11:0];
      converter_interrupt_enable <= (f == 0);
      global_interrupt_enable <= (f == 0);
      wb(1'b1, ADCC_OFS_CTRL_TWO, 8'(8'h55 + f * 8'h21));
      wb(1'b1, ADCC_OFS_CTRL_ONE, 8'h00);
      repeat (40) @(posedge clk);
      wb(1'b1, ADCC_OFS_CTRL_ONE, 8'h80);
      rd(ADCC_OFS_CTRL_ONE, 1'b1, 8'hc0);
      wb(1'b1, ADCC_OFS_CTRL_ONE, 8'h00);
      rd(ADCC_OFS_CTRL_ONE, 1'b1, 8'h40);
      polls = 0;
      while (q[6] === 1'b1 && polls < 1000) begin
        rd(ADCC_OFS_CTRL_ONE, 1'b0, 8'h00);
        polls++;
      end
      check(32'(q), 32'h0);
      check(32'(conv_irq_req), 32'h1);
      check(32'(result_value), 32'(level));
      rd(ADCC_OFS_RES_HI, 1'b1, f ? {4'h0, level[11:8]} : level[11:4]);
      rd(ADCC_OFS_RES_LO, 1'b1, f ? level[7:0] : {level[3:0], 4'h0});
      $display("conversion test %0d done", f);
    end
    wb(1'b1, ADCC_OFS_CTRL_ONE, 8'h10);
    repeat (3) @(negedge clk);
    check(32'(bandgap_to_converter), 32'h1);
    check(32'(conv_input_select), 32'h10);
    wb(1'b1, ADCC_OFS_CTRL_ONE, 8'h2b);
    repeat (3) @(negedge clk);
    check(32'(conv_powered), 32'h0);
    check(32'(bandgap_to_converter), 32'h0);
    check(32'(irqs), 32'h1);
    $display("routing test done");
    report_and_stop();
  end
endmodule : adcc_top_tb
